/* File: src/cpu_cache_hierarchy.sv */
// Instruction cache, prefetch queue, primary cache and backup cache control.
// Functional notes
// - Instruction fetches look in virtual_instr_cache first, data in primary.
// - Only references to memory space are cached, never I/O space.
// - A cacheable hit at any level makes no system_bus transaction.
// - prefetch_queue holds up to four longwords, filled from virtual_instr_cache or from miss data.
// - virtual_instr_cache is 2 KB direct mapped by virtual address.
// - A virtual_instr_cache miss becomes a read of the primary cache.
// - Primary cache: two ways, 256 blocks of 32 bytes, 20-bit tags.
// - Primary cache allocates on read miss only; writes pass through.
// - Four quadword subblocks per block, each valid; quadword access.
// - One parity bit per data byte and one per tag.
// - Primary cache answers in one cycle, a new access every cycle.
// - A write hit updates the primary cache and goes to backup cache.
// - Every backup cache invalidate also invalidates the primary cache.
// - Backup cache is direct mapped, quadword wide, 32-byte blocks.
// - Backup cache allocates on reads and writes, writes back.
// - Backup cache tags and data live in external static RAMs.
// - Backup cache invalidates on DMA hit and on replacement.
// - Invalidating an owned block writes it back and disowns it.
`timescale 1ns/1ps
`include "cache_map.svh"

module cpu_cache_hierarchy (
	input  wire logic                   sys_clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   fetch_redirect_i,
	input  wire cache_pkg::addr_t       fetch_va_i,
	output cache_pkg::addr_t            ifetch_va_o,
	input  wire cache_pkg::addr_t       ifetch_pa_i,
	output cache_pkg::lword_t           pq_data_o,
	output logic                        pq_valid_o,
	input  wire logic                   pq_take_i,
	input  wire logic                   d_req_valid_i,
	input  wire cache_pkg::dreq_s       d_req_i,
	output logic                        d_ready_o,
	output logic                        d_rvalid_o,
	output cache_pkg::qword_t           d_rdata_o,
	output logic                        pc_par_err_o,
	output cache_pkg::btag_port_s       btag_o,
	input  wire cache_pkg::btag_s       btag_rdata_i,
	output cache_pkg::bdata_port_s      bdata_o,
	input  wire cache_pkg::qword_t      bdata_rdata_i,
	output logic                        bus_cmd_valid_o,
	output cache_pkg::bus_cmd_s         bus_cmd_o,
	input  wire logic                   bus_cmd_ready_i,
	output logic                        bus_wvalid_o,
	output cache_pkg::bus_wbeat_s       bus_wbeat_o,
	input  wire logic                   bus_wready_i,
	input  wire logic                   bus_rvalid_i,
	input  wire cache_pkg::qword_t      bus_rdata_i,
	input  wire logic                   dma_inv_valid_i,
	input  wire cache_pkg::addr_t       dma_inv_addr_i,
	output logic                        dma_inv_ready_o
);

	typedef enum logic [3:0] {
		S_IDLE, S_TAG, S_CHK, S_RD, S_WCMD, S_WDAT, S_RCMD, S_FILL, S_DONE
	} state_e;

	function automatic cache_pkg::bmask_t par8(input cache_pkg::qword_t q);
		cache_pkg::bmask_t p;
		for (int i = 0; i < $bits(p); i++)
			p[i] = ^q[i*8 +: 8];
		return p;
	endfunction : par8

	function automatic cache_pkg::qword_t merge(
		input cache_pkg::qword_t o,
		input cache_pkg::qword_t n,
		input cache_pkg::bmask_t be);
		cache_pkg::qword_t r;
		for (int i = 0; i < $bits(be); i++)
			r[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
		return r;
	endfunction : merge

	// ========
	// Storage
	cache_pkg::qword_t   pc_data  [`PC_WAYS][`PC_SETS][`BLK_QW];
	cache_pkg::bmask_t   pc_par   [`PC_WAYS][`PC_SETS][`BLK_QW];
	cache_pkg::pc_tag_t  pc_tag   [`PC_WAYS][`PC_SETS];
	logic                pc_tpar  [`PC_WAYS][`PC_SETS];
	logic [`BLK_QW-1:0]  pc_sv    [`PC_WAYS][`PC_SETS];
	logic                pc_lru   [`PC_SETS];
	cache_pkg::qword_t   vic_data [`VIC_LINES][`BLK_QW];
	cache_pkg::vic_tag_t vic_tag  [`VIC_LINES];
	logic                vic_val  [`VIC_LINES];

	state_e              state_reg, state_next;
	logic [2:0]          beat_reg, beat_next;
	cache_pkg::dreq_s    req_reg;
	logic                dma_reg, istr_reg, cach_reg, wb_reg, ikill_reg;
	logic                way_reg;
	cache_pkg::btag_s    vict_reg;
	cache_pkg::qword_t   buf_reg [`BLK_QW];
	cache_pkg::qword_t   res_reg;
	cache_pkg::lword_t   pq_reg [`PQ_DEPTH];
	cache_pkg::lword_t   pq_next [`PQ_DEPTH];
	logic [2:0]          pq_cnt_reg, pq_cnt_next;
	cache_pkg::addr_t    fva_reg;
	logic                d_rvalid_reg, par_err_reg;
	cache_pkg::qword_t   d_rdata_reg;

	// ========
	// Primary cache lookup
	cache_pkg::addr_t    lk_addr;
	logic [6:0]          lk_idx;
	logic [1:0]          lk_qw;
	cache_pkg::pc_tag_t  lk_tag;
	logic [1:0]          tag_eq, hitw, blkw;
	logic                pc_hit, hway, blk_hit, bway, fill_way, par_bad;
	cache_pkg::qword_t   pc_rq;

	// Data requests own the single lookup port; fetch misses use it when no data request is valid.
	assign lk_addr = d_req_valid_i ? d_req_i.addr : ifetch_pa_i;
	assign lk_idx  = lk_addr[`PC_IDX_HI:`BLK_LO];
	assign lk_qw   = lk_addr[`QW_HI:`QW_LO];
	assign lk_tag  = lk_addr[`PC_TAG_HI:`PC_TAG_LO];
	for (genvar w = 0; w < `PC_WAYS; w++) begin : g_way
		assign tag_eq[w] = pc_tag[w][lk_idx] == lk_tag;
		assign hitw[w]   = tag_eq[w] & pc_sv[w][lk_idx][lk_qw];
		assign blkw[w]   = tag_eq[w] & (&pc_sv[w][lk_idx]);
	end
	assign pc_hit   = |hitw;
	assign hway     = hitw[1];
	assign blk_hit  = |blkw;
	assign bway     = blkw[1];
	assign pc_rq    = pc_data[hway][lk_idx][lk_qw];
	assign par_bad  = par8(pc_rq) != pc_par[hway][lk_idx][lk_qw] ||
		(^lk_tag) != pc_tpar[hway][lk_idx];
	assign fill_way = (pc_sv[0][lk_idx] == '0) ? 1'b0 :
		(pc_sv[1][lk_idx] == '0) ? 1'b1 : pc_lru[lk_idx];

	// ========
	// Prefetcher and instruction cache
	logic [5:0]          vidx;
	logic                vic_hit, want_i, i_done, vic_push, push, imiss;
	logic                vic_fill, idle, dbusy, dgo, igo, d_cach, dread_hit;
	cache_pkg::qword_t   push_q;

	assign vidx     = fva_reg[`VIC_IDX_HI:`BLK_LO];
	assign vic_hit  = vic_val[vidx] &&
		vic_tag[vidx] == fva_reg[`PC_TAG_HI:`VIC_TAG_LO];
	assign want_i   = pq_cnt_reg <= `PQ_ROOM && !fetch_redirect_i;
	assign i_done   = state_reg == S_DONE && istr_reg && !ikill_reg;
	assign vic_push = want_i && vic_hit && !i_done;
	assign push     = vic_push || i_done;
	assign push_q   = i_done ? res_reg : vic_data[vidx][fva_reg[`QW_HI:`QW_LO]];
	assign imiss    = want_i && !vic_hit && !d_req_valid_i;
	assign vic_fill = imiss && blk_hit;
	assign idle     = state_reg == S_IDLE && !dma_inv_valid_i;
	assign igo      = imiss && !blk_hit && idle;
	assign d_cach   = !d_req_i.addr[`IO_BIT];
	// A read hit may pass while the engine serves a fetch or a DMA probe.
	assign dbusy    = state_reg != S_IDLE && !istr_reg && !dma_reg;
	assign dread_hit = d_req_valid_i && !d_req_i.write && pc_hit && !dbusy;
	assign dgo      = d_req_valid_i && idle && (d_req_i.write || !pc_hit);
	assign d_ready_o = dread_hit || dgo;
	assign dma_inv_ready_o = state_reg == S_IDLE;
	assign ifetch_va_o = fva_reg;
	assign pq_valid_o  = pq_cnt_reg != '0;
	assign pq_data_o   = pq_reg[0];
	assign d_rvalid_o  = d_rvalid_reg;
	assign d_rdata_o   = d_rdata_reg;
	assign pc_par_err_o = par_err_reg;

	always_comb begin
		pq_next = pq_reg;
		pq_cnt_next = pq_cnt_reg;
		if (pq_take_i && pq_cnt_reg != '0) begin
			for (int i = 0; i < `PQ_DEPTH - 1; i++)
				pq_next[i] = pq_reg[i+1];
			pq_cnt_next = pq_cnt_reg - 3'h1;
		end
		if (fetch_redirect_i) begin
			pq_cnt_next = '0;
		end else if (push && fva_reg[`LW_BIT]) begin
			pq_next[pq_cnt_next[1:0]] = push_q[63:32];
			pq_cnt_next = pq_cnt_next + 3'h1;
		end else if (push) begin
			pq_next[pq_cnt_next[1:0]] = push_q[31:0];
			pq_next[pq_cnt_next[1:0] + 2'h1] = push_q[63:32];
			pq_cnt_next = pq_cnt_next + 3'h2;
		end
	end

	// ========
	// Backup cache sequencing
	cache_pkg::btag_s    rtag;
	cache_pkg::bc_tag_t  req_tag;
	cache_pkg::bc_idx_t  bidx;
	logic [1:0]          rqw, fill_beat;
	logic                bhit, chk, w_hit, need_wb, pinv_v, fill_v, pc_fill;
	logic                last_in, wlast, rd_arrive, adv;
	cache_pkg::addr_t    vaddr, pinv_a;
	cache_pkg::qword_t   fill_raw, fill_d;

	assign rtag      = btag_rdata_i;
	assign req_tag   = req_reg.addr[`PC_TAG_HI:`BC_TAG_LO];
	assign bidx      = req_reg.addr[`BC_IDX_HI:`BLK_LO];
	assign rqw       = req_reg.addr[`QW_HI:`QW_LO];
	assign chk       = state_reg == S_CHK;
	assign bhit      = rtag.valid && rtag.tag == req_tag;
	assign w_hit     = chk && !dma_reg && bhit && req_reg.write;
	assign need_wb   = chk && rtag.valid && rtag.owned &&
		(dma_reg ? bhit : !bhit);
	// The victim or DMA target leaves the primary cache before anything else.
	assign pinv_v    = chk && rtag.valid && (dma_reg ? bhit : !bhit);
	assign vaddr     = {rtag.tag, bidx, `BLK_PAD};
	assign pinv_a    = vaddr;
	assign rd_arrive = state_reg == S_RD && beat_reg != '0;
	assign fill_v    = (rd_arrive && !wb_reg) ||
		(state_reg == S_FILL && bus_rvalid_i);
	assign fill_beat = state_reg == S_RD ? beat_reg[1:0] - 2'h1 : beat_reg[1:0];
	assign fill_raw  = state_reg == S_RD ? bdata_rdata_i : bus_rdata_i;
	assign fill_d    = (req_reg.write && fill_beat == rqw) ?
		merge(fill_raw, req_reg.data, req_reg.be) : fill_raw;
	assign pc_fill   = fill_v && cach_reg && !req_reg.write;
	assign last_in   = state_reg == S_FILL && bus_rvalid_i &&
		beat_reg[1:0] == `BEAT_LAST;
	assign wlast     = state_reg == S_WDAT && bus_wready_i &&
		beat_reg[1:0] == `BEAT_LAST;
	assign adv       = state_reg == S_RD ||
		(state_reg == S_WDAT && bus_wready_i) ||
		(state_reg == S_FILL && bus_rvalid_i);

	// Static RAM ports are driven straight from the sequencer.
	assign btag_o.we    = w_hit || (last_in && cach_reg) ||
		(dma_reg && (wlast || (pinv_v && !rtag.owned)));
	assign btag_o.addr  = bidx;
	assign btag_o.wdata = dma_reg ? '0 :
		'{valid: 1'b1, owned: req_reg.write, tag: req_tag};
	assign bdata_o.we    = w_hit ||
		(state_reg == S_FILL && bus_rvalid_i && cach_reg);
	assign bdata_o.be    = w_hit ? req_reg.be : `BE_ALL;
	assign bdata_o.addr  = {bidx, w_hit ? rqw : beat_reg[1:0]};
	assign bdata_o.wdata = w_hit ? req_reg.data : fill_d;

	assign bus_cmd_valid_o = state_reg == S_WCMD || state_reg == S_RCMD;
	assign bus_cmd_o.cmd  = state_reg == S_WCMD ?
		(wb_reg ? cache_pkg::BUS_WRITE_DISOWN : cache_pkg::BUS_WRITE) :
		((cach_reg && req_reg.write) ? cache_pkg::BUS_READ_OWN :
		cache_pkg::BUS_READ);
	assign bus_cmd_o.addr = (state_reg == S_WCMD && wb_reg) ? vict_reg_addr() :
		{req_reg.addr[`PC_TAG_HI:`BLK_LO], `BLK_PAD};
	assign bus_wvalid_o     = state_reg == S_WDAT;
	assign bus_wbeat_o.data = buf_reg[beat_reg[1:0]];
	assign bus_wbeat_o.be   = wb_reg ? `BE_ALL :
		(beat_reg[1:0] == rqw ? req_reg.be : '0);

	function automatic cache_pkg::addr_t vict_reg_addr();
		return {vict_reg.tag, bidx, `BLK_PAD};
	endfunction : vict_reg_addr

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			S_IDLE: begin
				if (dma_inv_valid_i)
					state_next = S_TAG;
				else if (dgo && d_cach)
					state_next = S_TAG;
				else if (dgo)
					state_next = d_req_i.write ? S_WCMD : S_RCMD;
				else if (igo)
					state_next = ifetch_pa_i[`IO_BIT] ? S_RCMD : S_TAG;
			end
			S_TAG: state_next = S_CHK;
			S_CHK: begin
				if (need_wb)
					state_next = S_RD;
				else if (dma_reg || w_hit)
					state_next = S_IDLE;
				else
					state_next = bhit ? S_RD : S_RCMD;
			end
			S_RD: begin
				if (beat_reg == `RD_END)
					state_next = wb_reg ? S_WCMD : S_DONE;
			end
			S_WCMD: begin
				if (bus_cmd_ready_i)
					state_next = S_WDAT;
			end
			S_WDAT: begin
				if (wlast)
					state_next = (!wb_reg || dma_reg) ? S_IDLE : S_RCMD;
			end
			S_RCMD: begin
				if (bus_cmd_ready_i)
					state_next = S_FILL;
			end
			S_FILL: begin
				if (last_in)
					state_next = req_reg.write ? S_IDLE : S_DONE;
			end
			S_DONE: state_next = S_IDLE;
		endcase
	end
	assign beat_next = (state_next != state_reg) ? '0 :
		beat_reg + {2'h0, adv};

	// ========
	// Control registers
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= S_IDLE;
			beat_reg <= '0;
			req_reg <= '0;
			{dma_reg, istr_reg, cach_reg, wb_reg, ikill_reg} <= '0;
			{way_reg, d_rvalid_reg, par_err_reg} <= '0;
			vict_reg <= '0;
			pq_cnt_reg <= '0;
			fva_reg <= '0;
		end else begin
			state_reg <= state_next;
			beat_reg <= beat_next;
			pq_cnt_reg <= pq_cnt_next;
			if (fetch_redirect_i)
				fva_reg <= fetch_va_i;
			else if (push)
				fva_reg <= {fva_reg[`PC_TAG_HI:`QW_LO] + 29'h1, 3'h0};
			if (state_reg == S_IDLE && dma_inv_valid_i) begin
				req_reg <= '{write: 1'b0, addr: dma_inv_addr_i,
					data: '0, be: '0};
				{dma_reg, istr_reg, cach_reg} <= 3'h5;
			end else if (dgo) begin
				req_reg <= d_req_i;
				{dma_reg, istr_reg, cach_reg} <= {2'h0, d_cach};
				way_reg <= fill_way;
			end else if (igo) begin
				req_reg <= '{write: 1'b0, addr: ifetch_pa_i, data: '0, be: '0};
				{dma_reg, istr_reg} <= 2'h1;
				cach_reg <= !ifetch_pa_i[`IO_BIT];
				way_reg <= fill_way;
			end
			if (chk) begin
				vict_reg <= rtag;
				wb_reg <= need_wb;
			end else if (state_reg == S_IDLE) begin
				wb_reg <= 1'b0;
			end
			if (igo)
				ikill_reg <= 1'b0;
			else if (fetch_redirect_i && istr_reg && state_reg != S_IDLE)
				ikill_reg <= 1'b1;
			d_rvalid_reg <= dread_hit ||
				(state_reg == S_DONE && !istr_reg);
			par_err_reg <= dread_hit && par_bad;
		end
	end

	// ========
	// Data registers and arrays without reset
	always_ff @(posedge sys_clk_i) begin
		for (int i = 0; i < `PQ_DEPTH; i++)
			pq_reg[i] <= pq_next[i];
		if (dgo && d_req_i.write)
			buf_reg[lk_qw] <= d_req_i.data;
		if (rd_arrive)
			buf_reg[beat_reg[1:0] - 2'h1] <= bdata_rdata_i;
		if (fill_v && fill_beat == rqw)
			res_reg <= fill_d;
		d_rdata_reg <= dread_hit ? pc_rq : res_reg;
		if (vic_fill) begin
			for (int q = 0; q < `BLK_QW; q++)
				vic_data[vidx][q] <= pc_data[bway][lk_idx][q];
			vic_tag[vidx] <= fva_reg[`PC_TAG_HI:`VIC_TAG_LO];
		end
		if (pc_fill) begin
			pc_data[way_reg][req_reg.addr[`PC_IDX_HI:`BLK_LO]][fill_beat] <= fill_d;
			pc_par[way_reg][req_reg.addr[`PC_IDX_HI:`BLK_LO]][fill_beat] <=
				par8(fill_d);
			pc_tag[way_reg][req_reg.addr[`PC_IDX_HI:`BLK_LO]] <=
				req_reg.addr[`PC_TAG_HI:`PC_TAG_LO];
			pc_tpar[way_reg][req_reg.addr[`PC_IDX_HI:`BLK_LO]] <=
				^req_reg.addr[`PC_TAG_HI:`PC_TAG_LO];
		end else if (dgo && d_req_i.write && pc_hit) begin
			pc_data[hway][lk_idx][lk_qw] <= merge(pc_rq, d_req_i.data,
				d_req_i.be);
			pc_par[hway][lk_idx][lk_qw] <= par8(merge(pc_rq, d_req_i.data,
				d_req_i.be));
		end
	end

	// ========
	// Valid and replacement state
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			for (int s = 0; s < `PC_SETS; s++) begin
				pc_sv[0][s] <= '0;
				pc_sv[1][s] <= '0;
				pc_lru[s] <= 1'b0;
			end
			for (int v = 0; v < `VIC_LINES; v++)
				vic_val[v] <= 1'b0;
		end else begin
			if (vic_fill)
				vic_val[vidx] <= 1'b1;
			if (pinv_v) begin
				for (int w = 0; w < `PC_WAYS; w++)
					if (pc_tag[w][pinv_a[`PC_IDX_HI:`BLK_LO]] ==
						pinv_a[`PC_TAG_HI:`PC_TAG_LO])
						pc_sv[w][pinv_a[`PC_IDX_HI:`BLK_LO]] <= '0;
			end else if (pc_fill) begin
				pc_sv[way_reg][req_reg.addr[`PC_IDX_HI:`BLK_LO]] <=
					(fill_beat == '0 ? '0 :
					pc_sv[way_reg][req_reg.addr[`PC_IDX_HI:`BLK_LO]]) |
					(4'h1 << fill_beat);
				pc_lru[req_reg.addr[`PC_IDX_HI:`BLK_LO]] <= !way_reg;
			end
			if (dread_hit || (dgo && d_req_i.write && pc_hit))
				pc_lru[lk_idx] <= !hway;
		end
	end

endmodule : cpu_cache_hierarchy

/* File: inc/cache_map.svh */
// Address fields, geometry and sequencing constants of the cache hierarchy.
`ifndef CACHE_MAP_SVH
`define CACHE_MAP_SVH

// ========
// Address fields
`define IO_BIT      29
`define PC_TAG_HI   31
`define PC_TAG_LO   12
`define PC_IDX_HI   11
`define BLK_LO      5
`define QW_HI       4
`define QW_LO       3
`define LW_BIT      2
`define VIC_TAG_LO  11
`define VIC_IDX_HI  10
`define BC_TAG_LO   18
`define BC_IDX_HI   17
`define BLK_PAD     5'h00

// ========
// Geometry
`define PC_WAYS     2
`define PC_SETS     128
`define VIC_LINES   64
`define BLK_QW      4
`define PQ_DEPTH    4

// ========
// Sequencing
`define BEAT_LAST   2'h3
`define RD_END      3'h4
`define PQ_ROOM     3'h2
`define BE_ALL      8'hff

`endif

/* File: inc/cache_pkg.sv */
// Types shared by the cache hierarchy and its surroundings.
package cache_pkg;
	typedef logic [31:0] addr_t;
	typedef logic [63:0] qword_t;
	typedef logic [31:0] lword_t;
	typedef logic [7:0]  bmask_t;
	typedef logic [19:0] pc_tag_t;
	typedef logic [20:0] vic_tag_t;
	typedef logic [13:0] bc_tag_t;
	typedef logic [12:0] bc_idx_t;
	typedef logic [14:0] bc_qaddr_t;

	typedef enum logic [1:0] {
		BUS_READ,
		BUS_READ_OWN,
		BUS_WRITE,
		BUS_WRITE_DISOWN
	} bus_cmd_e;

	typedef struct packed {
		bus_cmd_e cmd;
		addr_t    addr;
	} bus_cmd_s;

	typedef struct packed {
		qword_t data;
		bmask_t be;
	} bus_wbeat_s;

	typedef struct packed {
		logic   write;
		addr_t  addr;
		qword_t data;
		bmask_t be;
	} dreq_s;

	typedef struct packed {
		logic    valid;
		logic    owned;
		bc_tag_t tag;
	} btag_s;

	typedef struct packed {
		logic    we;
		bc_idx_t addr;
		btag_s   wdata;
	} btag_port_s;

	typedef struct packed {
		logic      we;
		bmask_t    be;
		bc_qaddr_t addr;
		qword_t    wdata;
	} bdata_port_s;
endpackage : cache_pkg

/* File: dv/cpu_cache_hierarchy_assertions.sv */
// Port-level assertions for the cache hierarchy.
`timescale 1ns/1ps
module cpu_cache_hierarchy_assertions (
	input wire logic                  sys_clk_i,
	input wire logic                  sys_rst_i,
	input wire logic                  fetch_redirect_i,
	input wire logic                  pq_valid_o,
	input wire logic                  d_req_valid_i,
	input wire cache_pkg::dreq_s      d_req_i,
	input wire logic                  d_ready_o,
	input wire logic                  d_rvalid_o,
	input wire logic                  pc_par_err_o,
	input wire logic                  bus_cmd_valid_o,
	input wire cache_pkg::bus_cmd_s   bus_cmd_o,
	input wire logic                  bus_cmd_ready_i,
	input wire logic                  bus_wvalid_o,
	input wire cache_pkg::bus_wbeat_s bus_wbeat_o,
	input wire logic                  bus_wready_i,
	input wire logic                  dma_inv_valid_i,
	input wire logic                  dma_inv_ready_o
);
	// ========
	// Helpers
	cache_pkg::bus_cmd_e last_cmd_reg;
	wire take = d_req_valid_i && d_ready_o;
	always_ff @(posedge sys_clk_i) begin
		if (bus_cmd_valid_o && bus_cmd_ready_i)
			last_cmd_reg <= bus_cmd_o.cmd;
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_cmd_stall;
		bus_cmd_valid_o && !bus_cmd_ready_i;
	endsequence
	sequence s_disown_taken;
		bus_cmd_valid_o && bus_cmd_ready_i &&
			bus_cmd_o.cmd == cache_pkg::BUS_WRITE_DISOWN;
	endsequence
	// ========
	// Properties
	chk_cmd_align: assert property (
		bus_cmd_valid_o |-> bus_cmd_o.addr[4:0] == 5'h00)
		else $error("bus command not hexaword aligned");
	chk_cmd_hold: assert property (
		s_cmd_stall |=> bus_cmd_valid_o && $stable(bus_cmd_o))
		else $error("bus command dropped before ready");
	chk_beat_hold: assert property (
		bus_wvalid_o && !bus_wready_i |=> bus_wvalid_o && $stable(bus_wbeat_o))
		else $error("write beat dropped before ready");
	chk_disown_beat: assert property (
		s_disown_taken |-> ##[1:400] (bus_wvalid_o && bus_wready_i))
		else $error("write-back data never sent");
	chk_disown_be: assert property (
		bus_wvalid_o && last_cmd_reg == cache_pkg::BUS_WRITE_DISOWN
		|-> bus_wbeat_o.be == 8'hff) else $error("partial write-back beat");
	chk_io_nohit: assert property (
		take && !d_req_i.write && d_req_i.addr[29] |=> !d_rvalid_o)
		else $error("io read answered as a cache hit");
	chk_wr_noans: assert property (
		take && d_req_i.write |=> !d_rvalid_o)
		else $error("write produced a read answer");
	chk_idle_take: assert property (
		d_req_valid_i && dma_inv_ready_o && !dma_inv_valid_i |-> d_ready_o)
		else $error("idle cache refused a request");
	chk_par_pulse: assert property (
		pc_par_err_o |-> d_rvalid_o)
		else $error("parity flag without read answer");
	chk_flush_q: assert property (
		fetch_redirect_i |=> !pq_valid_o)
		else $error("prefetch queue not flushed");
	chk_rst_quiet: assert property (
		$fell(sys_rst_i) |-> !bus_cmd_valid_o && !bus_wvalid_o && !d_rvalid_o)
		else $error("activity right after reset");
endmodule : cpu_cache_hierarchy_assertions

bind cpu_cache_hierarchy cpu_cache_hierarchy_assertions i_chk (.*);

/* File: dv/sys_bus_model.sv */
// System bus memory with random stalls, plus the backup cache static RAMs.
`timescale 1ns/1ps
module sys_bus_model (
	input  wire logic                   clk_i,
	input  wire logic                   cmd_valid_i,
	input  wire cache_pkg::bus_cmd_s    cmd_i,
	output logic                        cmd_ready_o,
	input  wire logic                   wvalid_i,
	input  wire cache_pkg::bus_wbeat_s  wbeat_i,
	output logic                        wready_o,
	output logic                        rvalid_o,
	output cache_pkg::qword_t           rdata_o,
	input  wire cache_pkg::btag_port_s  btag_i,
	output cache_pkg::btag_s            btag_rdata_o,
	input  wire cache_pkg::bdata_port_s bdata_i,
	output cache_pkg::qword_t           bdata_rdata_o
);
	int                seed = 87;
	logic [31:0]       r;
	cache_pkg::addr_t  wbase_reg, rbase_reg, a;
	cache_pkg::qword_t q;
	logic [2:0]        wk = 3'h4, rk = 3'h4;
	bit [15:0]         tag_mem [8192];
	bit [63:0]         dat_mem [32768];
	cache_pkg::qword_t mem [cache_pkg::addr_t];
	initial begin
		cmd_ready_o = 1'b0;
		wready_o = 1'b0;
		rvalid_o = 1'b0;
		rdata_o = '0;
	end
	function automatic cache_pkg::qword_t rd(cache_pkg::addr_t x);
		return mem.exists(x) ? mem[x] : {~x, x};
	endfunction : rd
	always @(posedge clk_i) begin
		r = $random(seed);
		cmd_ready_o <= r[0];
		wready_o <= r[1];
		if (cmd_valid_i && cmd_ready_o) begin
			if (cmd_i.cmd >= cache_pkg::BUS_WRITE) begin
				wbase_reg <= cmd_i.addr;
				wk <= 3'h0;
			end else begin
				rbase_reg <= cmd_i.addr;
				rk <= 3'h0;
			end
		end
		if (wvalid_i && wready_o && wk != 3'h4) begin
			a = wbase_reg | {27'h0, wk[1:0], 3'h0};
			q = rd(a);
			for (int i = 0; i < 8; i++)
				if (wbeat_i.be[i]) q[i*8+:8] = wbeat_i.data[i*8+:8];
			mem[a] = q;
			wk <= wk + 3'h1;
		end
		if (rk != 3'h4 && r[2]) begin
			rvalid_o <= 1'b1;
			rdata_o <= rd(rbase_reg | {27'h0, rk[1:0], 3'h0});
			rk <= rk + 3'h1;
		end else begin
			rvalid_o <= 1'b0;
			rdata_o <= ~rdata_o;
		end
		btag_rdata_o <= cache_pkg::btag_s'(tag_mem[btag_i.addr]);
		if (btag_i.we) tag_mem[btag_i.addr] = btag_i.wdata;
		bdata_rdata_o <= dat_mem[bdata_i.addr];
		for (int i = 0; i < 8; i++)
			if (bdata_i.we && bdata_i.be[i])
				dat_mem[bdata_i.addr][i*8+:8] = bdata_i.wdata[i*8+:8];
	end
endmodule : sys_bus_model

/* File: dv/tb.sv */
// Self-checking bench for the cache hierarchy.
`timescale 1ns/1ps
module tb;
	logic                    sys_clk_i = 0, sys_rst_i = 1, fetch_redirect_i = 1;
	logic                    pq_take_i = 0, d_req_valid_i = 0, dma_inv_valid_i = 0;
	cache_pkg::addr_t        fetch_va_i = '0, dma_inv_addr_i = '0;
	cache_pkg::addr_t        ifetch_va_o, ifetch_pa_i;
	cache_pkg::dreq_s        d_req_i = '0;
	cache_pkg::lword_t       pq_data_o;
	cache_pkg::qword_t       d_rdata_o, bdata_rdata_i, bus_rdata_i, d0, d1;
	logic                    pq_valid_o, d_ready_o, d_rvalid_o, pc_par_err_o;
	logic                    bus_cmd_valid_o, bus_cmd_ready_i, bus_wvalid_o;
	logic                    bus_wready_i, bus_rvalid_i, dma_inv_ready_o;
	cache_pkg::btag_port_s   btag_o;
	cache_pkg::btag_s        btag_rdata_i;
	cache_pkg::bdata_port_s  bdata_o;
	cache_pkg::bus_cmd_s     bus_cmd_o;
	cache_pkg::bus_wbeat_s   bus_wbeat_o;
	cache_pkg::qword_t       exp_rd[$];
	cache_pkg::bus_cmd_s     exp_cmd[$];
	int                      fail_count = 0, n_tests = 0, seed = 87, k;
	// Identity translation keeps fetches in memory space.
	assign ifetch_pa_i = ifetch_va_o;
	cpu_cache_hierarchy i_dut (.*);
	sys_bus_model i_mem (.clk_i(sys_clk_i), .cmd_valid_i(bus_cmd_valid_o),
		.cmd_i(bus_cmd_o), .cmd_ready_o(bus_cmd_ready_i),
		.wvalid_i(bus_wvalid_o), .wbeat_i(bus_wbeat_o), .wready_o(bus_wready_i),
		.rvalid_o(bus_rvalid_i), .rdata_o(bus_rdata_i), .btag_i(btag_o),
		.btag_rdata_o(btag_rdata_i), .bdata_i(bdata_o),
		.bdata_rdata_o(bdata_rdata_i));
	initial forever #20 sys_clk_i = ~sys_clk_i;
	// ========
	// Tasks
	task automatic fail(string m);
		fail_count++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : fail
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	function automatic cache_pkg::qword_t pat(cache_pkg::addr_t x);
		return {~x, x};
	endfunction : pat
	function automatic cache_pkg::qword_t blend(cache_pkg::qword_t o,
		cache_pkg::qword_t n, cache_pkg::bmask_t be);
		for (int i = 0; i < 8; i++)
			if (be[i]) o[i*8+:8] = n[i*8+:8];
		return o;
	endfunction : blend
	task automatic wait_hi(ref logic s, input string m);
		int n;
		for (n = 0; n < 600 && s !== 1'b1; n++)
			@(posedge sys_clk_i);
		if (n == 600) begin
			fail(m);
			complete_run();
		end
	endtask : wait_hi
	task automatic acc(logic w, cache_pkg::addr_t a, cache_pkg::qword_t d,
		cache_pkg::bmask_t be);
		d_req_valid_i <= 1'b1;
		d_req_i <= '{w, a, d, be};
		@(posedge sys_clk_i);
		wait_hi(d_ready_o, "data request not taken");
	endtask : acc
	task automatic rd(cache_pkg::addr_t a, cache_pkg::qword_t e);
		exp_rd.push_back(e);
		acc(1'b0, a, '0, 8'h00);
	endtask : rd
	task automatic idle(int n);
		d_req_valid_i <= 1'b0;
		repeat (n) @(posedge sys_clk_i);
	endtask : idle
	task automatic cmd(cache_pkg::bus_cmd_e c, cache_pkg::addr_t a);
		exp_cmd.push_back('{c, a});
	endtask : cmd
	task automatic pop_lw(cache_pkg::addr_t a);
		cache_pkg::addr_t qa;
		qa = {a[31:3], 3'h0};
		wait_hi(pq_valid_o, "prefetch queue empty");
		n_tests++;
		if (pq_data_o !== (a[2] ? ~qa : qa)) fail("prefetch data");
		pq_take_i <= 1'b1;
		@(posedge sys_clk_i);
		pq_take_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : pop_lw
	// ========
	// Result monitor
	always @(posedge sys_clk_i) begin
		if (d_rvalid_o === 1'b1) begin
			n_tests++;
			if (exp_rd.size() == 0) fail("unexpected read answer");
			else if (d_rdata_o !== exp_rd.pop_front()) fail("read data");
		end
		if (bus_cmd_valid_o === 1'b1 && bus_cmd_ready_i === 1'b1) begin
			n_tests++;
			if (exp_cmd.size() == 0) fail("unexpected bus command");
			else if (bus_cmd_o !== exp_cmd.pop_front()) fail("bus command");
		end
	end
	// ========
	// Main sequence
	initial begin
		repeat (2) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		fetch_redirect_i <= 1'b0;
		cmd(cache_pkg::BUS_READ, 32'h0);
		cmd(cache_pkg::BUS_READ, 32'h20);
		for (k = 0; k < 8; k++) pop_lw(32'(k * 4));
		repeat (80) @(posedge sys_clk_i);
		fetch_va_i <= 32'hc;
		fetch_redirect_i <= 1'b1;
		@(posedge sys_clk_i);
		fetch_redirect_i <= 1'b0;
		@(posedge sys_clk_i);
		for (k = 3; k < 7; k++) pop_lw(32'(k * 4));
		$display("test fetch ended");
		d0 = {$random(seed), $random(seed)};
		d1 = {$random(seed), $random(seed)};
		for (k = 0; k < 2; k++) begin
			cmd(cache_pkg::BUS_READ, 32'h20000040);
			rd(32'h20000048, pat(32'h20000048));
		end
		cmd(cache_pkg::BUS_READ, 32'h1000);
		rd(32'h1008, pat(32'h1008));
		for (k = 0; k < 4; k++) rd(32'h1000 + 32'(k * 8), pat(32'h1000 + 32'(k * 8)));
		acc(1'b1, 32'h1008, d0, 8'h0f);
		idle(20);
		rd(32'h1008, blend(pat(32'h1008), d0, 8'h0f));
		idle(20);
		cmd(cache_pkg::BUS_WRITE_DISOWN, 32'h1000);
		cmd(cache_pkg::BUS_READ, 32'h1000);
		dma_inv_valid_i <= 1'b1;
		dma_inv_addr_i <= 32'h1000;
		@(posedge sys_clk_i);
		wait_hi(dma_inv_ready_o, "probe not taken");
		dma_inv_valid_i <= 1'b0;
		idle(40);
		rd(32'h1008, blend(pat(32'h1008), d0, 8'h0f));
		idle(1);
		$display("test coherence ended");
		cmd(cache_pkg::BUS_WRITE, 32'h20000000);
		acc(1'b1, 32'h20000010, d1, 8'hff);
		cmd(cache_pkg::BUS_READ, 32'h20000000);
		rd(32'h20000010, d1);
		cmd(cache_pkg::BUS_READ_OWN, 32'h4000);
		acc(1'b1, 32'h4008, d1, 8'hf0);
		rd(32'h4008, blend(pat(32'h4008), d1, 8'hf0));
		cmd(cache_pkg::BUS_WRITE_DISOWN, 32'h4000);
		cmd(cache_pkg::BUS_READ, 32'h44000);
		rd(32'h44008, pat(32'h44008));
		cmd(cache_pkg::BUS_READ, 32'h4000);
		rd(32'h4008, blend(pat(32'h4008), d1, 8'hf0));
		idle(60);
		$display("test write ended");
		n_tests++;
		if (exp_rd.size() != 0 || exp_cmd.size() != 0) fail("events missing");
		complete_run();
	end
endmodule : tb
